// >>> touch_qual_pkg.sv
// Purpose: Constants and carriers for the touch event qualifier
// Assumes: 250 MHz core clock, byte-wide register port
// Notes: Register offsets are byte addresses on the register port
package touch_qual_pkg;
  localparam int N_IN = 6;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_MS = 35;
  localparam int RECAL_MS = 600;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RECAL_CYCLES = RECAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_W = 24;
  localparam int RECAL_W = 28;
  localparam int HOLD_W = 5;

  localparam logic [7:0] ADDR_MAIN = 8'h00;
  localparam logic [7:0] ADDR_GEN_STATUS = 8'h02;
  localparam logic [7:0] ADDR_TOUCH_STATUS = 8'h03;
  localparam logic [7:0] ADDR_REPEAT_CFG = 8'h22;
  localparam logic [7:0] ADDR_PRESS_CFG = 8'h23;
  localparam logic [7:0] ADDR_RECAL = 8'h26;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h27;
  localparam logic [7:0] ADDR_AUTO_RPT = 8'h28;
  localparam logic [7:0] ADDR_MULTI_CFG = 8'h2a;
  localparam logic [7:0] ADDR_PAT_CFG = 8'h2b;
  localparam logic [7:0] ADDR_PAT_SEL = 8'h2d;

  localparam logic [7:0] RST_REPEAT_CFG = 8'h04;
  localparam logic [7:0] RST_PRESS_CFG = 8'h07;
  localparam logic [7:0] RST_RECAL = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h3f;
  localparam logic [7:0] RST_AUTO_RPT = 8'h3f;
  localparam logic [7:0] RST_MULTI_CFG = 8'h80;
  localparam logic [7:0] RST_PAT_CFG = 8'h00;
  localparam logic [7:0] RST_PAT_SEL = 8'h3f;

  localparam int INT_BIT = 0;
  localparam int STAT_PAT_BIT = 1;
  localparam int STAT_SIMULTANEOUS_STATUS_BIT = 2;
  localparam int REL_SET_BIT = 4;
  localparam int CODE_LSB = 0;
  localparam int BLK_EN_BIT = 7;
  localparam int LIMIT_LSB = 2;
  localparam int PAT_EN_BIT = 7;
  localparam int PTH_LSB = 2;
  localparam int CMP_BIT = 1;
  localparam int ALERT_BIT = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [N_IN-1:0][7:0] delta;
    logic [N_IN-1:0][6:0] thresh;
    logic [6:0] standby_thresh;
    logic standby;
    logic [N_IN-1:0] noise;
  } sense_s;
endpackage

// >>> touch_event_qualifier.sv
// Purpose: Qualifies touch events: recalibration, interrupts, repeat,
//   simultaneous-touch blocking and pattern detection
// Assumes: sense inputs synchronous to clk; recal_done pulses on success
// Notes: alert_n is the active-low interrupt pin
`timescale 1ns/1ns
module touch_event_qualifier
  import touch_qual_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int RECAL_CYC = RECAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_s req,
  input wire sense_s sense,
  input wire logic [N_IN-1:0] recal_done,
  output logic [7:0] reg_rdata,
  output logic alert_n,
  output logic [N_IN-1:0] recal_start
);

  function automatic logic [3:0] popcount(input logic [N_IN-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < N_IN; i++) begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction

  // Kept inputs first, then new touches in scan order until limit reached
  function automatic logic [N_IN-1:0] fill_sel(input logic [N_IN-1:0] base,
      input logic [N_IN-1:0] raw, input logic [3:0] lim);
    logic [N_IN-1:0] s;
    logic [3:0] c;
    s = base;
    c = popcount(base);
    for (int i = 0; i < N_IN; i++) begin
      if (raw[i] && !s[i] && c < lim) begin
        s[i] = 1'b1;
        c = c + 4'h1;
      end
    end
    return s;
  endfunction

  function automatic logic [6:0] frac_thr(input logic [6:0] t,
      input logic [1:0] code);
    unique case (code)
      2'h0: return t >> 3;
      2'h1: return t >> 2;
      2'h2: return (t >> 2) + (t >> 3);
      2'h3: return t;
    endcase
  endfunction

  logic [7:0] repeat_cfg_reg, press_cfg_reg, irq_en_reg, auto_rpt_reg;
  logic [7:0] multi_cfg_reg, pat_cfg_reg, pat_sel_reg;
  logic [N_IN-1:0] recal_reg, recal_next;
  logic [N_IN-1:0] touch_stat_reg, touch_stat_next;
  logic int_reg, int_next, simultaneous_status_reg, simultaneous_status_next, pat_reg, pat_next;
  logic [N_IN-1:0] valid_reg, valid_next, qual_reg, qual_next;
  logic pat_cond_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [7:0] rdata_next;
  logic [N_IN-1:0] start_next;

  wire wr_main = req.wr && req.addr == ADDR_MAIN;
  wire int_clear = wr_main && !req.wdata[INT_BIT];
  wire wr_recal = req.wr && req.addr == ADDR_RECAL;
  wire wr_repeat = req.wr && req.addr == ADDR_REPEAT_CFG;
  wire wr_press = req.wr && req.addr == ADDR_PRESS_CFG;
  wire wr_irq_en = req.wr && req.addr == ADDR_IRQ_EN;
  wire wr_auto_rpt = req.wr && req.addr == ADDR_AUTO_RPT;
  wire wr_multi = req.wr && req.addr == ADDR_MULTI_CFG;
  wire wr_pat_cfg = req.wr && req.addr == ADDR_PAT_CFG;
  wire wr_pat_sel = req.wr && req.addr == ADDR_PAT_SEL;
  wire tick = tick_cnt_reg == TICK_W'(TICK_CYC - 1);

  wire [3:0] rpt_code = repeat_cfg_reg[CODE_LSB +: 4];
  wire rel_setting = repeat_cfg_reg[REL_SET_BIT];
  wire [3:0] press_code = press_cfg_reg[CODE_LSB +: 4];
  wire blk_en = multi_cfg_reg[BLK_EN_BIT];
  wire [3:0] limit = {2'h0, multi_cfg_reg[LIMIT_LSB +: 2]} + 4'h1;
  wire pat_en = pat_cfg_reg[PAT_EN_BIT];
  wire [1:0] pth_code = pat_cfg_reg[PTH_LSB +: 2];
  wire cmp_pattern = pat_cfg_reg[CMP_BIT];
  wire pat_alert = pat_cfg_reg[ALERT_BIT];
  wire [N_IN-1:0] pat_sel = pat_sel_reg[N_IN-1:0];

  logic [N_IN-1:0] raw_touch, pat_hit, suppress, in_irq, spoil;

  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : gen_in
      logic [RECAL_W-1:0] recal_tmr_reg;
      logic [HOLD_W-1:0] hold_reg, rep_reg;
      wire [6:0] base_thr = sense.standby ? sense.standby_thresh
                                          : sense.thresh[g];
      wire [6:0] pthr = frac_thr(base_thr, pth_code);
      wire over = sense.delta[g] > {1'b0, base_thr};
      wire onset = qual_next[g] && !qual_reg[g];
      wire release_ev = !qual_next[g] && qual_reg[g];
      wire is_hold = hold_reg > ({1'b0, press_code} + 5'h01);
      wire rep_due = rep_reg == ({1'b0, rpt_code} + 5'h01);
      wire rpt_ev = tick && rep_due && is_hold && auto_rpt_reg[g]
                    && qual_reg[g];
      // Release irq always without repeat; setting low enables it with repeat
      wire rel_ok = !auto_rpt_reg[g] || !rel_setting;
      assign suppress[g] = recal_reg[g]
                           && recal_tmr_reg < RECAL_W'(RECAL_CYC);
      assign raw_touch[g] = over && !suppress[g];
      assign spoil[g] = suppress[g] && over;
      assign pat_hit[g] = sense.delta[g] > {1'b0, pthr} || sense.noise[g];
      assign in_irq[g] = irq_en_reg[g]
                         && (onset || (release_ev && rel_ok) || rpt_ev);
      always_ff @(posedge clk) begin
        if (rst || onset) begin
          hold_reg <= '0;
          rep_reg <= '0;
        end else if (tick && qual_reg[g]) begin
          if (hold_reg != '1) begin
            hold_reg <= hold_reg + 5'h01;
          end
          rep_reg <= rep_due ? 5'h01 : rep_reg + 5'h01;
        end
      end
      always_ff @(posedge clk) begin
        if (rst || start_next[g]) begin
          recal_tmr_reg <= '0;
        end else if (suppress[g]) begin
          recal_tmr_reg <= recal_tmr_reg + 28'h1;
        end
      end
    end
  endgenerate

  // Pattern match; an empty selection matches trivially in pattern mode
  wire pat_match = cmp_pattern ? ((pat_hit & pat_sel) == pat_sel)
                   : popcount(pat_hit) >= popcount(pat_sel);
  wire pat_cond = pat_en && pat_match;
  wire pat_rise = pat_cond && !pat_cond_reg;
  wire [N_IN-1:0] flag_rel = valid_reg & ~raw_touch;

  always_comb begin
    if (!blk_en) begin
      valid_next = raw_touch;
    end else if (|flag_rel) begin
      valid_next = fill_sel('0, raw_touch, limit);
    end else begin
      valid_next = fill_sel(valid_reg & raw_touch, raw_touch, limit);
    end
  end

  // Pattern condition blocks every touch for as long as it holds
  assign qual_next = pat_cond ? '0 : valid_next;

  // Set wins over a clear in the same cycle for all sticky bits
  assign touch_stat_next = (touch_stat_reg & ~{N_IN{int_clear}})
                           | (qual_next & ~qual_reg);
  assign simultaneous_status_next = (simultaneous_status_reg && !int_clear)
                     || (blk_en && popcount(raw_touch) > limit);
  assign pat_next = (pat_reg && !(int_clear && !pat_cond))
                    || pat_cond;
  assign int_next = (int_reg && !int_clear) || (|in_irq)
                    || (pat_rise && pat_alert);

  wire [N_IN-1:0] recal_wset = wr_recal ? req.wdata[N_IN-1:0] : '0;
  // A press during recalibration spoils it, so it is launched again
  assign start_next = (recal_wset & ~recal_reg)
                      | (recal_reg & spoil);
  assign recal_next = (recal_reg & ~recal_done) | recal_wset;

  always_comb begin
    unique case (req.addr)
      ADDR_MAIN: rdata_next = {7'h00, int_reg};
      ADDR_GEN_STATUS: rdata_next = {5'h00, simultaneous_status_reg, pat_reg, 1'b0};
      ADDR_TOUCH_STATUS: rdata_next = {2'h0, touch_stat_reg};
      ADDR_REPEAT_CFG: rdata_next = repeat_cfg_reg;
      ADDR_PRESS_CFG: rdata_next = press_cfg_reg;
      ADDR_RECAL: rdata_next = {2'h0, recal_reg};
      ADDR_IRQ_EN: rdata_next = irq_en_reg;
      ADDR_AUTO_RPT: rdata_next = auto_rpt_reg;
      ADDR_MULTI_CFG: rdata_next = multi_cfg_reg;
      ADDR_PAT_CFG: rdata_next = pat_cfg_reg;
      ADDR_PAT_SEL: rdata_next = pat_sel_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Reserved bits are masked on write so they always read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      repeat_cfg_reg <= RST_REPEAT_CFG;
    end else if (wr_repeat) begin
      repeat_cfg_reg <= req.wdata & 8'h1f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      press_cfg_reg <= RST_PRESS_CFG;
    end else if (wr_press) begin
      press_cfg_reg <= req.wdata & 8'h0f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_reg <= RST_IRQ_EN;
    end else if (wr_irq_en) begin
      irq_en_reg <= req.wdata & 8'h3f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_rpt_reg <= RST_AUTO_RPT;
    end else if (wr_auto_rpt) begin
      auto_rpt_reg <= req.wdata & 8'h3f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      multi_cfg_reg <= RST_MULTI_CFG;
    end else if (wr_multi) begin
      multi_cfg_reg <= req.wdata & 8'h8c;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pat_cfg_reg <= RST_PAT_CFG;
    end else if (wr_pat_cfg) begin
      pat_cfg_reg <= req.wdata & 8'h8f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pat_sel_reg <= RST_PAT_SEL;
    end else if (wr_pat_sel) begin
      pat_sel_reg <= req.wdata & 8'h3f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      recal_reg <= '0;
      recal_start <= '0;
    end else begin
      recal_reg <= recal_next;
      recal_start <= start_next;
    end
  end

  // Pin follows the main bit exactly, so both share int_next
  always_ff @(posedge clk) begin
    if (rst) begin
      touch_stat_reg <= '0;
      int_reg <= 1'b0;
      alert_n <= 1'b1;
      simultaneous_status_reg <= 1'b0;
      pat_reg <= 1'b0;
    end else begin
      touch_stat_reg <= touch_stat_next;
      int_reg <= int_next;
      alert_n <= !int_next;
      simultaneous_status_reg <= simultaneous_status_next;
      pat_reg <= pat_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      valid_reg <= '0;
      qual_reg <= '0;
      pat_cond_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      qual_reg <= qual_next;
      pat_cond_reg <= pat_cond;
    end
  end

  // One shared tick keeps every input's hold and repeat timing in phase
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      reg_rdata <= 8'h00;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 24'h1;
      if (req.rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule

// >>> touch_qual_sva.sv
// Purpose: Port checks for the touch qualifier
// Assumes: standby held low by the bench
// Notes: Shadows mirror host writes to the irq enable, auto-repeat, multi-touch and pattern config registers
`timescale 1ns/1ns
module touch_qual_sva
  import touch_qual_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_s req,
  input wire sense_s sense,
  input wire logic [N_IN-1:0] recal_done,
  input wire logic [7:0] reg_rdata,
  input wire logic alert_n,
  input wire logic [N_IN-1:0] recal_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] ie_reg, rp_reg, mc_reg, pc_reg;
  logic [N_IN-1:0] hot, p1_reg, p2_reg;
  logic cal_reg;
  wire clr_w = req.wr && req.addr == ADDR_MAIN && !req.wdata[INT_BIT];
  wire [N_IN-1:0] en_hot = hot & ie_reg[N_IN-1:0];
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      hot[i] = sense.delta[i] > {1'b0, sense.thresh[i]};
    end
  end
  always_ff @(posedge clk) begin
    p1_reg <= rst ? '0 : en_hot;
    p2_reg <= rst ? '0 : p1_reg;
    if (rst) begin
      ie_reg <= RST_IRQ_EN;
      rp_reg <= RST_AUTO_RPT;
      mc_reg <= RST_MULTI_CFG;
      pc_reg <= RST_PAT_CFG;
      cal_reg <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == ADDR_IRQ_EN) ie_reg <= req.wdata & 8'h3f;
      if (req.addr == ADDR_AUTO_RPT) rp_reg <= req.wdata & 8'h3f;
      if (req.addr == ADDR_MULTI_CFG) mc_reg <= req.wdata & 8'h8c;
      if (req.addr == ADDR_PAT_CFG) pc_reg <= req.wdata & 8'h8f;
      if (req.addr == ADDR_RECAL) cal_reg <= 1'b1;
    end
  end
  AST_RST_IDLE: assert property (disable iff (1'b0)
    rst |=> alert_n && recal_start == '0) else $error("reset outputs");
  AST_HOLD: assert property (!alert_n && !clr_w |=> !alert_n)
    else $error("alert dropped");
  AST_QUIET: assert property (alert_n && !pc_reg[ALERT_BIT]
    && en_hot == 0 && p1_reg == 0 && p2_reg == 0 && !sense.standby
    |=> alert_n) else $error("spurious alert");
  AST_TOUCH: assert property ((en_hot & ~p1_reg) != 0
    && !mc_reg[BLK_EN_BIT] && !pc_reg[PAT_EN_BIT] && !cal_reg
    |-> ##[1:2] !alert_n) else $error("touch without alert");
  AST_RECAL: assert property (req.wr && req.addr == ADDR_RECAL
    && req.wdata[0] && !cal_reg |-> ##[1:2] recal_start[0])
    else $error("no recal start");
  AST_RD_IE: assert property (req.rd && req.addr == ADDR_IRQ_EN
    |=> reg_rdata == ie_reg) else $error("irq enable read");
  AST_RD_RPT: assert property (req.rd && req.addr == ADDR_AUTO_RPT
    |=> reg_rdata == rp_reg) else $error("repeat enable read");
  AST_RD_MC: assert property (req.rd && req.addr == ADDR_MULTI_CFG
    |=> reg_rdata == mc_reg) else $error("block config read");
  AST_RD_PC: assert property (req.rd && req.addr == ADDR_PAT_CFG
    |=> reg_rdata == pc_reg) else $error("pattern config read");
endmodule

// >>> host_model.sv
// Purpose: Host controller register access model
// Assumes: one access at a time
// Notes: Tasks are called from the bench
`timescale 1ns/1ns
module host_model
  import touch_qual_pkg::*;
(
  input wire logic clk,
  output reg_req_s req,
  input wire logic [7:0] reg_rdata
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  // Zero in the main bit releases latched status
  task automatic clr();
    wr(ADDR_MAIN, 8'h00);
  endtask
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the touch qualifier
// Assumes: short tick and recal counts
// Notes: Sense inputs are driven directly by the bench
`timescale 1ns/1ns
module tb_top
  import touch_qual_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_s req;
  sense_s sense;
  logic [N_IN-1:0] recal_done, recal_start;
  logic [7:0] reg_rdata, d;
  logic alert_n;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam int SIM_TICK = 10;
  always #2 clk = ~clk;
  touch_event_qualifier #(.TICK_CYC(SIM_TICK), .RECAL_CYC(50)) u_dut (
    .clk(clk), .rst(rst), .req(req), .sense(sense),
    .recal_done(recal_done), .reg_rdata(reg_rdata),
    .alert_n(alert_n), .recal_start(recal_start));
  host_model u_host (.clk(clk), .req(req), .reg_rdata(reg_rdata));
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a, m, e);
    u_host.rd(a, d);
    chk(nm, d & m, e);
  endtask
  task automatic touch(input logic [5:0] m, input logic [7:0] v);
    @(posedge clk);
    for (int i = 0; i < N_IN; i++) sense.delta[i] <= m[i] ? v : 8'h00;
    repeat (3) @(posedge clk);
  endtask
  task automatic idle();
    touch(6'h00, 8'h00);
    u_host.clr();
    repeat (2) @(posedge clk);
  endtask
  task automatic s_touch();
    touch(6'h01, 8'h40);
    chk("alert", {7'h0, alert_n}, 8'h00);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h01);
    idle();
    chk("alert", {7'h0, alert_n}, 8'h01);
    u_host.wr(ADDR_IRQ_EN, 8'h3e);
    touch(6'h01, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h01);
    chk("alert", {7'h0, alert_n}, 8'h01);
    idle();
    u_host.wr(ADDR_IRQ_EN, 8'h3f);
  endtask
  task automatic s_block();
    touch(6'h0a, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h02);
    rc("gs", ADDR_GEN_STATUS, 8'h04, 8'h04);
    touch(6'h08, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'h08, 8'h08);
    idle();
    u_host.wr(ADDR_MULTI_CFG, 8'h84);
    touch(6'h0e, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h06);
    idle();
    u_host.wr(ADDR_MULTI_CFG, 8'h04);
    touch(6'h0e, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h0e);
    rc("gs", ADDR_GEN_STATUS, 8'h04, 8'h00);
    idle();
  endtask
  // Counts edges until the pin falls; gives up after 200
  task automatic wait_low(output int n);
    n = 0;
    while (alert_n !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Hold after two ticks, repeat every two ticks; clears cost three edges
  task automatic s_repeat();
    int n;
    u_host.wr(ADDR_PRESS_CFG, 8'h00);
    u_host.wr(ADDR_REPEAT_CFG, 8'h01);
    touch(6'h01, 8'h40);
    chk("alert", {7'h0, alert_n}, 8'h00);
    u_host.clr();
    @(posedge clk);
    wait_low(n);
    chk("hold", {7'h0, n >= 2 * SIM_TICK - 3 && n < 3 * SIM_TICK},
        8'h01);
    u_host.clr();
    @(posedge clk);
    wait_low(n);
    chk("period", 8'(n), 8'(2 * SIM_TICK - 3));
    u_host.clr();
    @(posedge clk);
    touch(6'h00, 8'h00);
    chk("rel", {7'h0, alert_n}, 8'h00);
    u_host.clr();
    u_host.wr(ADDR_AUTO_RPT, 8'h3e);
    touch(6'h01, 8'h40);
    u_host.clr();
    repeat (6 * SIM_TICK) @(posedge clk);
    chk("norpt", {7'h0, alert_n}, 8'h01);
    touch(6'h00, 8'h00);
    chk("rel", {7'h0, alert_n}, 8'h00);
    idle();
    u_host.wr(ADDR_AUTO_RPT, 8'h3f);
    u_host.wr(ADDR_REPEAT_CFG, RST_REPEAT_CFG);
    u_host.wr(ADDR_PRESS_CFG, RST_PRESS_CFG);
  endtask
  task automatic s_recal();
    u_host.wr(ADDR_RECAL, 8'h01);
    rc("cal", ADDR_RECAL, 8'hff, 8'h01);
    touch(6'h01, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h00);
    touch(6'h00, 8'h00);
    recal_done <= 6'h01;
    @(posedge clk);
    recal_done <= 6'h00;
    rc("cal", ADDR_RECAL, 8'hff, 8'h00);
    idle();
  endtask
  task automatic s_pattern();
    u_host.wr(ADDR_PAT_SEL, 8'h03);
    u_host.wr(ADDR_PAT_CFG, 8'h83);
    touch(6'h03, 8'h08);
    rc("gs", ADDR_GEN_STATUS, 8'h02, 8'h02);
    chk("alert", {7'h0, alert_n}, 8'h00);
    idle();
    rc("gs", ADDR_GEN_STATUS, 8'h02, 8'h00);
    u_host.wr(ADDR_PAT_CFG, 8'h8c);
    touch(6'h30, 8'h40);
    rc("gs", ADDR_GEN_STATUS, 8'h02, 8'h02);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h00);
    chk("alert", {7'h0, alert_n}, 8'h01);
    touch(6'h10, 8'h40);
    rc("ts", ADDR_TOUCH_STATUS, 8'hff, 8'h10);
    idle();
  endtask
  initial begin
    sense = '0;
    sense.thresh = {N_IN{7'h20}};
    sense.standby_thresh = 7'h20;
    recal_done = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc("ie", ADDR_IRQ_EN, 8'hff, 8'h3f);
    rc("rpt", ADDR_AUTO_RPT, 8'hff, 8'h3f);
    rc("mc", ADDR_MULTI_CFG, 8'hff, 8'h80);
    rc("pc", ADDR_PAT_CFG, 8'hff, 8'h00);
    s_touch();
    s_block();
    s_repeat();
    s_recal();
    s_pattern();
    summarize();
  end
endmodule
bind touch_event_qualifier touch_qual_sva u_sva (.clk(clk), .rst(rst),
  .req(req), .sense(sense), .recal_done(recal_done),
  .reg_rdata(reg_rdata), .alert_n(alert_n), .recal_start(recal_start));
